//--- common/sccp_pkg.sv
// constants for the channel protection register bank
// assumes a 20 MHz core clock and 16-bit registers
package sccp_pkg;
    // clock rate in kHz, used to turn times into cycles
    localparam int CLK_KHZ = 20000;
    // register offsets and widths
    localparam int AW = 8;
    localparam int DW = 16;
    localparam logic [7:0] OFS_VRES = 8'h13;
    localparam logic [7:0] OFS_CFG = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h15;
    localparam logic [15:0] RST_VRES = 16'h0000;
    localparam logic [15:0] RST_CFG = 16'h0000;
    localparam logic [15:0] RST_STAT = 16'h0000;
    // voltage result fields
    localparam int VRES_FRESH_BIT = 10;
    localparam int VRES_VAL_W = 10;
    // config fields
    localparam int CFG_COOL_LSB = 14;
    localparam int CFG_DLY_LSB = 9;
    localparam int CFG_ICL_LSB = 7;
    localparam int CFG_TRIP_LSB = 3;
    localparam int CFG_NOM_LSB = 0;
    localparam logic [15:0] CFG_WR_MASK = 16'hC7FF;
    // status bit positions
    localparam int ST_LATCHED = 11;
    localparam int ST_ANY_FLT = 10;
    localparam int ST_SW_ON = 9;
    localparam int ST_HEAT = 7;
    localparam int ST_WAKE = 6;
    localparam int ST_OTEMP = 5;
    localparam int ST_ILIM = 4;
    localparam int ST_SHORT = 3;
    localparam int ST_OFF_OL = 2;
    // sticky vector slots
    localparam int SK_SHORT = 0;
    localparam int SK_ILIM = 1;
    localparam int SK_OTEMP = 2;
    localparam int SK_HEAT = 3;
    localparam int SK_WAKE = 4;
    localparam int SK_W = 5;
    // protection times in microseconds and milliseconds
    localparam int DLY_US_0 = 200;
    localparam int DLY_US_1 = 400;
    localparam int DLY_US_2 = 1000;
    localparam int DLY_US_3 = 2000;
    localparam int COOL_MS_1 = 800;
    localparam int COOL_MS_2 = 2000;
    localparam int COOL_MS_3 = 4000;
    localparam int RETRY_MS = 1;
    // derived cycle counts; least times round up
    localparam int DLY_CYC_0 = (DLY_US_0 * CLK_KHZ + 999) / 1000;
    localparam int DLY_CYC_1 = (DLY_US_1 * CLK_KHZ + 999) / 1000;
    localparam int DLY_CYC_2 = (DLY_US_2 * CLK_KHZ + 999) / 1000;
    localparam int DLY_CYC_3 = (DLY_US_3 * CLK_KHZ + 999) / 1000;
    localparam int COOL_CYC_1 = COOL_MS_1 * CLK_KHZ;
    localparam int COOL_CYC_2 = COOL_MS_2 * CLK_KHZ;
    localparam int COOL_CYC_3 = COOL_MS_3 * CLK_KHZ;
    localparam int RETRY_CYC = RETRY_MS * CLK_KHZ;
    // timer counter width, holds the 4 s cooldown
    localparam int TW = 27;
    // channel-1 protection states
    typedef enum logic [1:0] {
        SCCP_OFF, SCCP_ON, SCCP_COOL, SCCP_LATCHED
    } sccp_state_t;
endpackage

//--- verilog/sccp_timer.sv
// run-length timer: expires after limit cycles of run
// assumes limit is at least one and stable while running
`timescale 1ns/100ps
module sccp_timer #(
    parameter int CW = 27
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic [CW-1:0] limit,
    output logic expired
);
    // elapsed cycles of the current run
    logic [CW-1:0] count;

    // restart whenever run drops, saturate at limit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
        end else if (!run) begin
            count <= '0;
        end else if (count != limit) begin
            count <= count + 1'b1;
        end
    end

    // expiry holds until run drops
    assign expired = run && (count == limit);
endmodule

//--- verilog/sccp_sticky.sv
// clear-on-read fault flags
// set wins over clear; a flag only clears once its cause is gone
`timescale 1ns/100ps
module sccp_sticky #(
    parameter int W = 5
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] active,
    input wire logic rd_clear,
    output logic [W-1:0] flag
);
    // a read clears only flags whose condition ended
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flag <= '0;
        end else begin
            flag <= set | (flag & (active | {W{~rd_clear}}));
        end
    end
endmodule

//--- verilog/sccp_regs.sv
// channel-1 voltage result, channel-1 wire-heat config and
// channel-2 fault status, with the channel-1 protection sequencer
// assumes a serial front end issuing one-cycle read/write strobes
// on clk, and analog fault levels arriving asynchronously
`timescale 1ns/100ps
module sccp_regs
    import sccp_pkg::*;
#(
    parameter int DLY_CYC_1_P = sccp_pkg::DLY_CYC_1,
    parameter int DLY_CYC_2_P = sccp_pkg::DLY_CYC_2,
    parameter int DLY_CYC_3_P = sccp_pkg::DLY_CYC_3,
    parameter int COOL_CYC_1_P = sccp_pkg::COOL_CYC_1,
    parameter int COOL_CYC_2_P = sccp_pkg::COOL_CYC_2,
    parameter int COOL_CYC_3_P = sccp_pkg::COOL_CYC_3,
    parameter int RETRY_CYC_P = sccp_pkg::RETRY_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    // register port from the serial front end
    input wire logic [sccp_pkg::AW-1:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [sccp_pkg::DW-1:0] reg_wdata,
    output logic [sccp_pkg::DW-1:0] reg_rdata,
    output logic reg_rvalid,
    // channel-1 converter result
    input wire logic adc_v_valid,
    input wire logic [sccp_pkg::VRES_VAL_W-1:0] adc_v_data,
    // global and per-channel settings from neighbour registers
    input wire logic wire_heat_protect_enable,
    input wire logic ch1_fault_latch_select,
    input wire logic ch1_switch_request,
    input wire logic ch1_switch_state_write,
    input wire logic ch2_supply_short_detect_enable,
    input wire logic ch2_off_open_load_enable,
    // channel-1 analog conditions, asynchronous
    input wire logic ch1_over_delayed_off_current,
    input wire logic ch1_wire_heat_trip,
    // channel-2 analog conditions, asynchronous
    input wire logic ch2_latched_off,
    input wire logic ch2_switch_on,
    input wire logic ch2_reverse_current,
    input wire logic ch2_overtemp,
    input wire logic ch2_on_open_load,
    input wire logic ch2_off_open_load_trip,
    input wire logic ch2_short_to_supply,
    input wire logic ch2_wire_heat_fault,
    input wire logic ch2_overcurrent_off,
    input wire logic ch2_low_power_wake,
    // channel-1 drive and settings out
    output logic ch1_output_on,
    output logic [1:0] ch1_delayed_off_current,
    output logic [3:0] ch1_wire_heat_trip_level,
    output logic [2:0] ch1_nominal_current
);
    // elaboration guards against unusable counts
    if (DLY_CYC_1_P < 1 || DLY_CYC_2_P < 1 || DLY_CYC_3_P < 1 ||
        COOL_CYC_1_P < 1 || COOL_CYC_2_P < 1 || COOL_CYC_3_P < 1 ||
        RETRY_CYC_P < 1) begin : g_min
        $error("sccp_regs: timing counts must be at least one");
    end
    if (COOL_CYC_3_P >= (1 << TW) || RETRY_CYC_P >= (1 << TW)) begin : g_max
        $error("sccp_regs: timing count exceeds timer width");
    end

    // number of asynchronous inputs brought in
    localparam int NS = 12;
    localparam int S_LATCH = 0;
    localparam int S_ON = 1;
    localparam int S_REV = 2;
    localparam int S_OTEMP = 3;
    localparam int S_ONOL = 4;
    localparam int S_OFFOL = 5;
    localparam int S_SHORT = 6;
    localparam int S_HEAT = 7;
    localparam int S_ILIM = 8;
    localparam int S_WAKE = 9;
    localparam int S_C1_DLY = 10;
    localparam int S_C1_HEAT = 11;

    // raw pin levels, first and second sync stage
    logic [NS-1:0] async_in;
    logic [NS-1:0] sync_a;
    logic [NS-1:0] sync_b;
    // register contents
    logic [VRES_VAL_W-1:0] vres_value;
    logic vres_fresh;
    logic [DW-1:0] cfg;
    // decoded accesses
    logic rd_vres;
    logic rd_stat;
    logic wr_cfg;
    // channel-2 sticky flags and their inputs
    logic [SK_W-1:0] sk_set;
    logic [SK_W-1:0] sk_active;
    logic [SK_W-1:0] sk_flag;
    logic short_en_q;
    logic wake_q;
    // assembled status word
    logic [DW-1:0] stat_word;
    // channel-1 sequencer
    sccp_state_t state;
    sccp_state_t next_state;
    logic [TW-1:0] dly_limit;
    logic [TW-1:0] wait_limit;
    logic [TW-1:0] next_wait_limit;
    logic dly_expired;
    logic wait_expired;
    logic heat_trip;
    // address of the last read, for checks
    logic [AW-1:0] last_addr;

    // delayed-off time per code
    function automatic logic [TW-1:0] dly_cycles(input logic [1:0] code);
        unique case (code)
            2'h0: dly_cycles = TW'(DLY_CYC_0);
            2'h1: dly_cycles = TW'(DLY_CYC_1_P);
            2'h2: dly_cycles = TW'(DLY_CYC_2_P);
            2'h3: dly_cycles = TW'(DLY_CYC_3_P);
        endcase
    endfunction

    // cooldown time per code; code zero is never timed
    function automatic logic [TW-1:0] cool_cycles(input logic [1:0] code);
        unique case (code)
            2'h0: cool_cycles = TW'(COOL_CYC_1_P);
            2'h1: cool_cycles = TW'(COOL_CYC_1_P);
            2'h2: cool_cycles = TW'(COOL_CYC_2_P);
            2'h3: cool_cycles = TW'(COOL_CYC_3_P);
        endcase
    endfunction

    assign async_in = {ch1_wire_heat_trip, ch1_over_delayed_off_current,
                       ch2_low_power_wake, ch2_overcurrent_off,
                       ch2_wire_heat_fault, ch2_short_to_supply,
                       ch2_off_open_load_trip, ch2_on_open_load,
                       ch2_overtemp, ch2_reverse_current,
                       ch2_switch_on, ch2_latched_off};

    // two-stage synchroniser; only sync_b is used downstream
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= async_in;
            sync_b <= sync_a;
        end
    end

    // address decode
    assign rd_vres = reg_rd_en && (reg_addr == OFS_VRES);
    assign rd_stat = reg_rd_en && (reg_addr == OFS_STAT);
    assign wr_cfg = reg_wr_en && (reg_addr == OFS_CFG);

    // voltage result store
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vres_value <= RST_VRES[VRES_VAL_W-1:0];
        end else if (adc_v_valid) begin
            vres_value <= adc_v_data;
        end
    end

    // freshness flag: new conversion beats the clearing read
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vres_fresh <= RST_VRES[VRES_FRESH_BIT];
        end else if (adc_v_valid) begin
            vres_fresh <= 1'b1;
        end else if (rd_vres) begin
            vres_fresh <= 1'b0;
        end
    end

    // config register; reserved bits stay zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg <= RST_CFG;
        end else if (wr_cfg) begin
            cfg <= reg_wdata & CFG_WR_MASK;
        end
    end

    // settings driven straight from the config flops
    // current threshold field
    assign ch1_delayed_off_current = cfg[CFG_ICL_LSB +: 2];
    assign ch1_wire_heat_trip_level = cfg[CFG_TRIP_LSB +: 4];
    assign ch1_nominal_current = cfg[CFG_NOM_LSB +: 3];

    // enable registered one cycle; a short still held when it comes on sets the flag
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            short_en_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            short_en_q <= ch2_supply_short_detect_enable;
            wake_q <= sync_b[S_WAKE];
        end
    end

    // sticky flag sources
    always_comb begin
        sk_set = '0;
        sk_active = '0;
        sk_set[SK_SHORT] = sync_b[S_SHORT] && short_en_q;
        sk_active[SK_SHORT] = sync_b[S_SHORT];
        sk_set[SK_ILIM] = sync_b[S_ILIM];
        sk_active[SK_ILIM] = sync_b[S_ILIM];
        // held until cooled below reset level
        sk_set[SK_OTEMP] = sync_b[S_OTEMP];
        sk_active[SK_OTEMP] = sync_b[S_OTEMP];
        sk_set[SK_HEAT] = sync_b[S_HEAT] && wire_heat_protect_enable;
        sk_active[SK_HEAT] = sync_b[S_HEAT];
        sk_set[SK_WAKE] = sync_b[S_WAKE] && !wake_q;
        sk_active[SK_WAKE] = 1'b0;
    end

    sccp_sticky #(
        .W(SK_W)
    ) u_sticky (
        .clk(clk),
        .reset_n(reset_n),
        .set(sk_set),
        .active(sk_active),
        .rd_clear(rd_stat),
        .flag(sk_flag)
    );

    // status word, live levels plus sticky flags
    always_comb begin
        stat_word = RST_STAT;
        stat_word[ST_LATCHED] = sync_b[S_LATCH];
        stat_word[ST_ANY_FLT] = sync_b[S_REV] | sync_b[S_OTEMP] |
            sync_b[S_ONOL] | sync_b[S_OFFOL] | sync_b[S_SHORT];
        stat_word[ST_SW_ON] = sync_b[S_ON];
        stat_word[ST_HEAT] = sk_flag[SK_HEAT];
        stat_word[ST_WAKE] = sk_flag[SK_WAKE];
        stat_word[ST_OTEMP] = sk_flag[SK_OTEMP];
        stat_word[ST_ILIM] = sk_flag[SK_ILIM];
        stat_word[ST_SHORT] = sk_flag[SK_SHORT];
        // meaningful only when detection is on
        stat_word[ST_OFF_OL] = sync_b[S_OFFOL] && ch2_off_open_load_enable;
    end

    // read data, one cycle after the strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
            last_addr <= '0;
        end else begin
            reg_rvalid <= reg_rd_en;
            if (reg_rd_en) begin
                last_addr <= reg_addr;
            end
            if (!reg_rd_en) begin
                reg_rdata <= reg_rdata;
            end else if (reg_addr == OFS_VRES) begin
                reg_rdata <= {5'h00, vres_fresh, vres_value};
            end else if (reg_addr == OFS_CFG) begin
                reg_rdata <= cfg;
            end else if (reg_addr == OFS_STAT) begin
                reg_rdata <= stat_word;
            end else begin
                // unmapped addresses read zero
                reg_rdata <= '0;
            end
        end
    end

    // delayed-off timer runs in SCCP_ON while current is over threshold
    assign dly_limit = dly_cycles(cfg[CFG_DLY_LSB +: 2]);
    // wire-heat trip counts only with protection on
    assign heat_trip = sync_b[S_C1_HEAT] && wire_heat_protect_enable;

    sccp_timer #(
        .CW(TW)
    ) u_dly (
        .clk(clk),
        .reset_n(reset_n),
        .run((state == SCCP_ON) && sync_b[S_C1_DLY]),
        .limit(dly_limit),
        .expired(dly_expired)
    );

    sccp_timer #(
        .CW(TW)
    ) u_wait (
        .clk(clk),
        .reset_n(reset_n),
        .run(state == SCCP_COOL),
        .limit(wait_limit),
        .expired(wait_expired)
    );

    // next-state logic for the channel-1 sequencer
    always_comb begin
        next_state = state;
        next_wait_limit = wait_limit;
        unique case (state)
            SCCP_OFF: begin
                if (ch1_switch_request) begin
                    next_state = SCCP_ON;
                end
            end
            SCCP_ON: begin
                if (!ch1_switch_request) begin
                    next_state = SCCP_OFF;
                end else if (heat_trip) begin
                    if (cfg[CFG_COOL_LSB +: 2] == 2'h0) begin
                        next_state = SCCP_LATCHED;
                    end else begin
                        next_state = SCCP_COOL;
                        next_wait_limit = cool_cycles(cfg[CFG_COOL_LSB +: 2]);
                    end
                end else if (dly_expired) begin
                    if (ch1_fault_latch_select) begin
                        next_state = SCCP_LATCHED;
                    end else begin
                        next_state = SCCP_COOL;
                        next_wait_limit = TW'(RETRY_CYC_P);
                    end
                end
            end
            SCCP_COOL: begin
                if (wait_expired) begin
                    next_state = ch1_switch_request ? SCCP_ON : SCCP_OFF;
                end
            end
            SCCP_LATCHED: begin
                if (ch1_switch_state_write) begin
                    next_state = ch1_switch_request ? SCCP_ON : SCCP_OFF;
                end
            end
        endcase
    end

    // sequencer state and output drive, registered together
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= SCCP_OFF;
            wait_limit <= TW'(RETRY_CYC_P);
            ch1_output_on <= 1'b0;
        end else begin
            state <= next_state;
            wait_limit <= next_wait_limit;
            ch1_output_on <= (next_state == SCCP_ON);
        end
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    fresh_set_a: assert property (adc_v_valid |=> vres_fresh)
        else $error("fresh flag not set by conversion");
    fresh_clear_a: assert property (
        rd_vres && !adc_v_valid |=> !vres_fresh)
        else $error("fresh flag survived a read");
    vres_upper_a: assert property (
        reg_rvalid && last_addr == OFS_VRES |-> reg_rdata[15:11] == 5'h00)
        else $error("voltage result upper bits not zero");
    cfg_reserved_a: assert property (cfg[13:11] == 3'h0)
        else $error("reserved config bits written");
    cool_latch_a: assert property (
        state == SCCP_ON && ch1_switch_request && heat_trip &&
        cfg[CFG_COOL_LSB +: 2] == 2'h0 |=> state == SCCP_LATCHED && !ch1_output_on)
        else $error("code zero did not latch off");
    dly_shut_a: assert property (
        state == SCCP_ON && ch1_switch_request && !heat_trip && dly_expired
        |=> !ch1_output_on)
        else $error("delayed turn-off missed");
    latch_hold_a: assert property (
        state == SCCP_LATCHED && !ch1_switch_state_write
        |=> state == SCCP_LATCHED)
        else $error("latched channel left without write");
    any_fault_a: assert property (
        reg_rvalid && last_addr == OFS_STAT
        |-> reg_rdata[10] == $past(|sync_b[S_SHORT:S_REV]))
        else $error("any-fault bit wrong");
    sticky_keep_a: assert property (
        !rd_stat |=> ($past(sk_flag) & ~sk_flag) == '0)
        else $error("fault flag lost without a read");
    read_first_a: assert property (
        rd_stat |=> reg_rdata[7:3] == $past(stat_word[7:3]))
        else $error("read did not return pre-clear flags");
    heat_gate_a: assert property (
        !wire_heat_protect_enable && !sk_flag[SK_HEAT]
        |=> !sk_flag[SK_HEAT])
        else $error("wire-heat flag set while disabled");

    fresh_read_c: cover property (adc_v_valid ##[1:20] rd_vres);
    cooldown_c: cover property (state == SCCP_COOL ##1 state == SCCP_ON);
    latch_exit_c: cover property (state == SCCP_LATCHED ##1 state != SCCP_LATCHED);
    sticky_clear_c: cover property (sk_flag[SK_ILIM] && rd_stat ##1 !sk_flag[SK_ILIM]);
endmodule

//--- sim/sccp_host.sv
// host model: drives register reads and writes on the bank
// assumes requests are taken at the rising edge of clk
`timescale 1ns/100ps
module sccp_host (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [15:0] reg_wdata
);
    // idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
    end
    // one strobe per access; released lines show the inverse
    // so a stale value is never mistaken for a fresh one
    task xfer(input logic wr, input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = wr;
        reg_rd_en = !wr;
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule

//--- sim/sccp_regs_bench.sv
// bench for the channel protection register bank
// assumes the host model owns the register port
`timescale 1ns/100ps
module sccp_regs_bench;
    import sccp_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr;
    logic reg_wr_en, reg_rd_en, reg_rvalid, on;
    logic [15:0] reg_wdata, reg_rdata, e_q, w;
    logic [9:0] f2 = '0; // channel-2 conditions
    logic [2:0] en = '0; // short detect, heat enable, off open load
    logic [4:0] c1 = '0; // latch, request, state write, over, trip
    logic av = 1'b0;
    logic [9:0] ad = '0;
    logic [1:0] icl;
    logic [3:0] trip;
    logic [2:0] nom;
    logic [15:0] q[$]; // expected read data, oldest first
    int failures = 0;
    int checks_done = 0;
    int seed = 32'h77E5;
    // stimulus {en, f2}, status with cause held, then after it is gone
    localparam logic [12:0] ST [12] = '{13'h0200, 13'h0100, 13'h0080, 13'h0040,
        13'h0020, 13'h0410, 13'h1008, 13'h0008, 13'h0804, 13'h0004, 13'h0002, 13'h0001};
    localparam logic [15:0] E1 [12] = '{16'h0800, 16'h0200, 16'h0400, 16'h0420,
        16'h0400, 16'h0404, 16'h0408, 16'h0400, 16'h0080, 16'h0000, 16'h0010, 16'h0040};
    localparam logic [15:0] E2 [12] = '{16'h0000, 16'h0000, 16'h0000, 16'h0020,
        16'h0000, 16'h0000, 16'h0008, 16'h0000, 16'h0080, 16'h0000, 16'h0010, 16'h0000};
    // wake flag has no live cause, so the read while held already clears it
    always #25 clk = ~clk;
    sccp_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata));
    // short counts keep the sequencer waits brief
    sccp_regs #(.DLY_CYC_1_P(20), .COOL_CYC_1_P(30), .RETRY_CYC_P(10)) i_dut (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .adc_v_valid(av), .adc_v_data(ad),
        .wire_heat_protect_enable(en[1]), .ch1_fault_latch_select(c1[4]),
        .ch1_switch_request(c1[3]), .ch1_switch_state_write(c1[2]),
        .ch2_supply_short_detect_enable(en[2]), .ch2_off_open_load_enable(en[0]),
        .ch1_over_delayed_off_current(c1[1]), .ch1_wire_heat_trip(c1[0]),
        .ch2_latched_off(f2[9]), .ch2_switch_on(f2[8]), .ch2_reverse_current(f2[7]),
        .ch2_overtemp(f2[6]), .ch2_on_open_load(f2[5]), .ch2_off_open_load_trip(f2[4]),
        .ch2_short_to_supply(f2[3]), .ch2_wire_heat_fault(f2[2]),
        .ch2_overcurrent_off(f2[1]), .ch2_low_power_wake(f2[0]),
        .ch1_output_on(on), .ch1_delayed_off_current(icl),
        .ch1_wire_heat_trip_level(trip), .ch1_nominal_current(nom));
    // compare and count
    task check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // note the expected word, then issue the read
    task rd(input logic [7:0] a, input logic [15:0] e);
        q.push_back(e);
        i_host.xfer(1'b0, a, 16'h0000);
    endtask
    task results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // read data stands one cycle; caught at the falling edge
    always @(negedge clk) begin
        if (reg_rvalid === 1'b1) begin
            e_q = q.pop_front();
            check("read data", reg_rdata, e_q);
        end
    end
    // hang guard, well past the expected run length
    initial begin
        #150000;
        failures++;
        results;
    end
    initial begin
        tick(6);
        reset_n = 1'b1;
        rd(OFS_VRES, RST_VRES);
        rd(OFS_STAT, RST_STAT);
        rd(8'h20, 16'h0000);
        // writable fields only; reserved bits stay zero
        w = 16'($random(seed));
        i_host.xfer(1'b1, OFS_CFG, w);
        rd(OFS_CFG, w & CFG_WR_MASK);
        check("current select", 16'(icl), 16'(w[8:7]));
        check("trip level", 16'(trip), 16'(w[6:3]));
        check("nominal current", 16'(nom), 16'(w[2:0]));
        // fresh conversion, then a second read sees it stale
        tick(1);
        ad = 10'($random(seed));
        av = 1'b1;
        w = {6'h00, ad};
        tick(1);
        av = 1'b0;
        ad = ~ad;
        i_host.xfer(1'b1, OFS_VRES, 16'hFFFF);
        rd(OFS_VRES, w | 16'h0400);
        rd(OFS_VRES, w);
        // each fault: held, gone, then cleared by the read before
        for (int i = 0; i < 12; i++) begin
            {en, f2} = ST[i];
            tick(4);
            rd(OFS_STAT, E1[i]);
            {en, f2} = '0;
            tick(4);
            rd(OFS_STAT, E2[i]);
            rd(OFS_STAT, 16'h0000);
        end
        // delayed turn-off latches with latch select set
        i_host.xfer(1'b1, OFS_CFG, 16'h0200);
        c1 = 5'b11000;
        tick(3);
        check("drive on", 16'(on), 16'h0001);
        c1 = 5'b11010;
        tick(12);
        check("drive before limit", 16'(on), 16'h0001);
        tick(16);
        check("drive after limit", 16'(on), 16'h0000);
        c1 = 5'b11000;
        tick(10);
        check("drive latched", 16'(on), 16'h0000);
        c1 = 5'b11100;
        tick(1);
        c1 = 5'b11000;
        tick(3);
        check("drive rearmed", 16'(on), 16'h0001);
        // wire-heat trip with cooldown code 1 retries on its own
        i_host.xfer(1'b1, OFS_CFG, 16'h4000);
        en = 3'b010;
        c1 = 5'b11001;
        tick(3);
        c1 = 5'b11000;
        tick(3);
        check("drive tripped", 16'(on), 16'h0000);
        tick(15);
        check("drive cooling", 16'(on), 16'h0000);
        tick(25);
        check("drive retried", 16'(on), 16'h0001);
        // cooldown code zero latches; only a switch-state write releases
        i_host.xfer(1'b1, OFS_CFG, 16'h0200);
        c1 = 5'b11001;
        tick(3);
        c1 = 5'b11000;
        tick(3);
        check("drive held off", 16'(on), 16'h0000);
        tick(35);
        check("drive still off", 16'(on), 16'h0000);
        c1 = 5'b11100;
        tick(1);
        // no latch select: delayed turn-off waits the retry time
        c1 = 5'b01010;
        tick(3);
        check("drive released", 16'(on), 16'h0001);
        tick(25);
        check("drive in retry wait", 16'(on), 16'h0000);
        c1 = 5'b01000;
        tick(10);
        check("drive after retry", 16'(on), 16'h0001);
        tick(4);
        // every noted read must have been answered
        check("reads answered", 16'(q.size()), 16'h0000);
        results;
    end
endmodule
